// *** asqc_top.sv ***
// converter sequencer with limit compare, AXI4-Lite register slave
// assumes: analog core gives adc_done/adc_data from outside this clock;
// pwm flags come from logic on aclk
`timescale 1ns/100ps
`include "asqc_cfg.svh"
module asqc_top (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire asqc_pkg::asqc_addr_t s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire asqc_pkg::asqc_word_t s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire asqc_pkg::asqc_addr_t s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output asqc_pkg::asqc_word_t    s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	input  wire logic               adc_done,
	input  wire asqc_pkg::asqc_sample_t adc_data,
	input  wire logic               pwm_period_flag,
	input  wire logic [2:0]         pwm_duty_flag,
	output logic                    adc_power_on,
	output logic                    adc_clk_tick,
	output logic                    conv_start,
	output logic [3:0]              ext_mux_sel,
	output logic                    ext_connect,
	output logic                    opamp_connect,
	output logic                    ground_connect,
	output asqc_pkg::asqc_pins_t    pin_analog_sel,
	output asqc_pkg::asqc_pins_t    pullup_disable,
	output logic                    limit_event
);
	import asqc_pkg::*;

	asqc_top_t  s_reg, s_next;
	logic       dly_go;
	asqc_pins_t ext_hit;
	logic       en, fmt, ext_src, code_ok;
	logic [2:0] src;
	logic [3:0] code;
	logic [1:0] duty_idx;
	logic       pwm_now;

	// ****************************************************************
	// source and channel decode
	// ****************************************************************
	assign en = s_reg.ctrl[`ASQC_CM_EN];
	assign fmt = s_reg.ctrl[`ASQC_CM_FMT];
	assign src = s_reg.srcclk[`ASQC_TR_PATH:`ASQC_TR_EVT];
	assign code = s_reg.ctrl[3:0];
	assign ext_src = (src == 3'h0) || src[2];
	assign code_ok = code != `ASQC_CH_RSVD && code <= `ASQC_CH_MAX;

	// one bit per input pin, none for the reserved code
	for (genvar i = 0; i < 14; i++) begin : g_pin
		assign ext_hit[i] = ext_src && code_ok && code == 4'(i);
	end

	// ****************************************************************
	// start delay and conversion clock
	// ****************************************************************
	asqc_delay #(.DW(`ASQC_DLY_W)) u_delay (
		.aclk   (aclk),
		.aresetn(aresetn),
		.arm    (en && s_reg.trig[`ASQC_TR_PATH] && !s_reg.busy
		         && pwm_now && !s_reg.pwm_q),
		.dly_en (s_reg.trig[`ASQC_TR_DLYEN]),
		.count  (s_reg.dly),
		.cancel (!en),
		.go     (dly_go)
	);

	asqc_clkdiv #(.SEL_W(`ASQC_DIV_SEL_W)) u_clkdiv (
		.aclk   (aclk),
		.aresetn(aresetn),
		.run    (en),
		.sel    (s_reg.srcclk[2:0]),
		.tick   (adc_clk_tick)
	);

	// selected pwm flag as plain nets, so the arm term follows the flags
	assign duty_idx = (s_reg.trig[1:0] == 2'h3) ? 2'h2 : s_reg.trig[1:0];
	assign pwm_now = s_reg.trig[`ASQC_TR_EVT] ? pwm_duty_flag[duty_idx]
		: pwm_period_flag;

	// masked readback of a low or high limit byte
	function automatic asqc_byte_t lo_view(input asqc_byte_t v);
		return fmt ? v : {v[7:4], 4'h0};
	endfunction : lo_view

	function automatic asqc_byte_t hi_view(input asqc_byte_t v);
		return fmt ? {4'h0, v[3:0]} : v;
	endfunction : hi_view

	// limit condition on a fresh sample
	function automatic logic limit_hit(input asqc_sample_t r);
		asqc_sample_t lo, hi;
		logic lo_c, hi_c;
		lo = asqc_align(fmt, s_reg.lol_hi, s_reg.lol_lo);
		hi = asqc_align(fmt, s_reg.upl_hi, s_reg.upl_lo);
		lo_c = r <= lo;
		hi_c = r >= hi;
		unique case ({s_reg.trig[`ASQC_TR_HVE], s_reg.trig[`ASQC_TR_LVE]})
			2'h0: return r > lo && r < hi;
			2'h1: return lo_c;
			2'h2: return hi_c;
			2'h3: return lo_c || hi_c;
		endcase
	endfunction : limit_hit

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		logic wr_go, hit, start_req, done_edge;
		wr_go = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid;
		hit = 1'b1;
		s_next = s_reg;
		s_next.conv_start = 1'b0;
		s_next.cmp_evt = 1'b0;
		// write address and data taken in either order
		if (s_axi_awvalid && s_reg.awready) begin
			s_next.aw_have = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_reg.wready) begin
			s_next.w_have = 1'b1;
			s_next.w_data = s_axi_wdata[7:0];
			s_next.w_strb0 = s_axi_wstrb[0];
		end
		if (s_reg.bvalid && s_axi_bready) s_next.bvalid = 1'b0;
		// register write once both halves are held
		if (wr_go) begin
			s_next.aw_have = 1'b0;
			s_next.w_have = 1'b0;
			s_next.bvalid = 1'b1;
			unique case (s_reg.aw_addr)
				`ASQC_OFF_RES_LO, `ASQC_OFF_RES_HI: ;
				`ASQC_OFF_LOL_LO: if (s_reg.w_strb0) s_next.lol_lo = s_reg.w_data;
				`ASQC_OFF_LOL_HI: if (s_reg.w_strb0) s_next.lol_hi = s_reg.w_data;
				`ASQC_OFF_UPL_LO: if (s_reg.w_strb0) s_next.upl_lo = s_reg.w_data;
				`ASQC_OFF_UPL_HI: if (s_reg.w_strb0) s_next.upl_hi = s_reg.w_data;
				`ASQC_OFF_CTRL: if (s_reg.w_strb0)
					s_next.ctrl = s_reg.w_data & `ASQC_CTRL_WMASK;
				`ASQC_OFF_SRCCLK: if (s_reg.w_strb0)
					s_next.srcclk = s_reg.w_data & `ASQC_SC_WMASK;
				`ASQC_OFF_TRIG: if (s_reg.w_strb0)
					s_next.trig = s_reg.w_data & `ASQC_TR_WMASK;
				`ASQC_OFF_DLY: if (s_reg.w_strb0) s_next.dly = s_reg.w_data;
				default: hit = 1'b0;
			endcase
			s_next.bresp = hit ? `ASQC_RESP_OKAY : `ASQC_RESP_SLVERR;
		end
		s_next.awready = !s_next.aw_have;
		s_next.wready = !s_next.w_have;
		// read: data stands from the same edge that takes the address
		if (s_reg.rvalid && s_axi_rready) s_next.rvalid = 1'b0;
		if (s_axi_arvalid && s_reg.arready) begin
			s_next.rvalid = 1'b1;
			s_next.rresp = `ASQC_RESP_OKAY;
			unique case (s_axi_araddr)
				`ASQC_OFF_RES_LO: s_next.rdata = fmt ? s_reg.result[7:0]
					: {s_reg.result[3:0], 4'h0};
				`ASQC_OFF_RES_HI: s_next.rdata = fmt
					? {4'h0, s_reg.result[11:8]} : s_reg.result[11:4];
				`ASQC_OFF_LOL_LO: s_next.rdata = lo_view(s_reg.lol_lo);
				`ASQC_OFF_LOL_HI: s_next.rdata = hi_view(s_reg.lol_hi);
				`ASQC_OFF_UPL_LO: s_next.rdata = lo_view(s_reg.upl_lo);
				`ASQC_OFF_UPL_HI: s_next.rdata = hi_view(s_reg.upl_hi);
				`ASQC_OFF_CTRL: s_next.rdata = {s_reg.ctrl[7], s_reg.busy,
					s_reg.ctrl[5:0]};
				`ASQC_OFF_SRCCLK: s_next.rdata = s_reg.srcclk;
				`ASQC_OFF_TRIG: s_next.rdata = s_reg.trig;
				`ASQC_OFF_DLY: s_next.rdata = s_reg.dly;
				default: begin
					s_next.rdata = `ASQC_RST_BYTE;
					s_next.rresp = `ASQC_RESP_SLVERR;
				end
			endcase
		end
		s_next.arready = !s_next.rvalid;
		// two-flop sync of the analog core answer
		s_next.done_s1 = adc_done;
		s_next.done_s2 = s_reg.done_s1;
		s_next.done_s3 = s_reg.done_s2;
		s_next.data_s1 = adc_data;
		s_next.data_s2 = s_reg.data_s1;
		done_edge = s_reg.done_s2 && !s_reg.done_s3;
		// trigger edges
		s_next.start_q = s_reg.ctrl[`ASQC_CM_START];
		s_next.pwm_q = pwm_now;
		start_req = s_reg.trig[`ASQC_TR_PATH] ? dly_go
			: s_reg.start_q && !s_reg.ctrl[`ASQC_CM_START];
		if (en && !s_reg.busy && start_req) begin
			s_next.busy = 1'b1;
			s_next.conv_start = 1'b1;
		end
		// store the sample when the core reports completion
		if (s_reg.busy && done_edge) begin
			s_next.busy = 1'b0;
			s_next.result = s_reg.data_s2;
			s_next.cmp_evt = limit_hit(s_reg.data_s2);
		end
		if (!en) begin
			s_next.result = '0;
			s_next.busy = 1'b0;
			s_next.conv_start = 1'b0;
		end
		// analog routing and pin control
		s_next.power_on = en;
		s_next.ext_mux = code;
		s_next.ext_connect = en && ext_src && code_ok;
		s_next.opamp_on = en && src == `ASQC_SRC_OPAMP;
		s_next.ground_on = en && src[2:1] == 2'h1;
		s_next.pin_analog = ext_hit;
		s_next.pullup_off = ext_hit;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign s_axi_awready = s_reg.awready;
	assign s_axi_wready = s_reg.wready;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = s_reg.arready;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rresp = s_reg.rresp;
	assign s_axi_rdata = {24'h000000, s_reg.rdata};
	assign adc_power_on = s_reg.power_on;
	assign conv_start = s_reg.conv_start;
	assign ext_mux_sel = s_reg.ext_mux;
	assign ext_connect = s_reg.ext_connect;
	assign opamp_connect = s_reg.opamp_on;
	assign ground_connect = s_reg.ground_on;
	assign pin_analog_sel = s_reg.pin_analog;
	assign pullup_disable = s_reg.pullup_off;
	assign limit_event = s_reg.cmp_evt;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_start_sets_busy: assert property (
		conv_start |-> s_reg.busy && $past(!s_reg.busy))
		else $error("start without busy rising");
	a_done_clears_busy: assert property (
		s_reg.busy && s_reg.done_s2 && !s_reg.done_s3 |=> !s_reg.busy
		&& (!en || s_reg.result == $past(s_reg.data_s2)))
		else $error("completion did not store result");
	a_disable_clears: assert property (
		!en |=> s_reg.result == '0 && !s_reg.busy)
		else $error("result kept while disabled");
	a_limits_hold: assert property (
		!en && !(s_reg.aw_have && s_reg.w_have) |=>
		$stable({s_reg.lol_lo, s_reg.lol_hi, s_reg.upl_lo, s_reg.upl_hi}))
		else $error("limits changed by disable");
	a_busy_blocks: assert property (
		s_reg.busy |=> !conv_start)
		else $error("start accepted while busy");
	a_sw_start: assert property (
		en && !s_reg.busy && !s_reg.trig[`ASQC_TR_PATH] && s_reg.start_q
		&& !s_reg.ctrl[`ASQC_CM_START] |=> conv_start ##1 !conv_start)
		else $error("start bit fall missed");
	a_internal_off: assert property (
		src == `ASQC_SRC_OPAMP |=> !ext_connect && opamp_connect == $past(en))
		else $error("external input left on");
	a_reserved_code: assert property (
		code == `ASQC_CH_RSVD || code > `ASQC_CH_MAX |=>
		pin_analog_sel == '0 && !ext_connect && pullup_disable == '0)
		else $error("reserved channel connected");
	a_res_hi_zero: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr == `ASQC_OFF_RES_HI
		&& fmt |=> s_axi_rdata[7:4] == 4'h0)
		else $error("unused result bits not zero");
	a_below_low: assert property (
		s_reg.busy && s_reg.done_s2 && !s_reg.done_s3 && en
		&& s_reg.trig[4:3] == 2'h1
		&& s_reg.data_s2 <= asqc_align(fmt, s_reg.lol_hi, s_reg.lol_lo)
		|=> limit_event)
		else $error("low limit event missed");

	a_limit_quiet: assert property (
		!(s_reg.busy && s_reg.done_s2 && !s_reg.done_s3) |=> !limit_event)
		else $error("limit event without a stored sample");

	a_pin_onehot: assert property (
		$onehot0(pin_analog_sel) && pullup_disable == pin_analog_sel)
		else $error("pin select not one-hot");

	c_sw_conv: cover property (conv_start ##[1:300] !s_reg.busy);
	c_pwm_direct: cover property (dly_go && s_reg.dly == 8'h00);
	c_pwm_delay: cover property (dly_go && s_reg.dly > 8'h02);
	c_limit: cover property (limit_event);
	c_bad_read: cover property (s_axi_rvalid && s_axi_rresp != 2'h0);
endmodule : asqc_top

// *** asqc_cfg.svh ***
// constants of the converter sequencer: offsets, fields, resets, counts
// assumes: included by the package and by every design file
`ifndef ASQC_CFG_SVH
`define ASQC_CFG_SVH
// ****************************************************************
// register byte offsets
// ****************************************************************
`define ASQC_AW          8
`define ASQC_OFF_RES_LO  8'h00
`define ASQC_OFF_RES_HI  8'h04
`define ASQC_OFF_LOL_LO  8'h08
`define ASQC_OFF_LOL_HI  8'h0C
`define ASQC_OFF_UPL_LO  8'h10
`define ASQC_OFF_UPL_HI  8'h14
`define ASQC_OFF_CTRL    8'h18
`define ASQC_OFF_SRCCLK  8'h1C
`define ASQC_OFF_TRIG    8'h20
`define ASQC_OFF_DLY     8'h24
// ****************************************************************
// field positions, masks, codes and resets
// ****************************************************************
`define ASQC_CM_START    7
`define ASQC_CM_BUSY     6
`define ASQC_CM_EN       5
`define ASQC_CM_FMT      4
`define ASQC_TR_PATH     7
`define ASQC_TR_DLYEN    6
`define ASQC_TR_EVT      5
`define ASQC_TR_HVE      4
`define ASQC_TR_LVE      3
`define ASQC_CTRL_WMASK  8'hBF
`define ASQC_SC_WMASK    8'hE7
`define ASQC_TR_WMASK    8'hFB
`define ASQC_SRC_OPAMP   3'h1
`define ASQC_CH_RSVD     4'h6
`define ASQC_CH_MAX      4'hD
`define ASQC_RST_BYTE    8'h00
`define ASQC_RESP_OKAY   2'h0
`define ASQC_RESP_SLVERR 2'h2
`define ASQC_DIV_SEL_W   3
`define ASQC_DLY_W       8
`endif

// *** asqc_pkg.sv ***
// types of the converter sequencer
// assumes: asqc_cfg.svh is on the include path
`include "asqc_cfg.svh"
package asqc_pkg;
	typedef logic [31:0]          asqc_word_t;
	typedef logic [`ASQC_AW-1:0]  asqc_addr_t;
	typedef logic [11:0]          asqc_sample_t;
	typedef logic [7:0]           asqc_byte_t;
	typedef logic [13:0]          asqc_pins_t;
	typedef enum logic {DLY_IDLE, DLY_COUNT} asqc_dly_state_t;

	// whole state of the top module
	typedef struct packed {
		logic aw_have; asqc_addr_t aw_addr;
		logic w_have; asqc_byte_t w_data; logic w_strb0;
		logic awready; logic wready; logic bvalid; logic [1:0] bresp;
		logic arready; logic rvalid; logic [1:0] rresp;
		asqc_byte_t rdata;
		asqc_sample_t result;
		asqc_byte_t lol_lo; asqc_byte_t lol_hi;
		asqc_byte_t upl_lo; asqc_byte_t upl_hi;
		asqc_byte_t ctrl; asqc_byte_t srcclk;
		asqc_byte_t trig; asqc_byte_t dly;
		logic busy; logic start_q; logic pwm_q;
		logic done_s1; logic done_s2; logic done_s3;
		asqc_sample_t data_s1; asqc_sample_t data_s2;
		logic conv_start; logic cmp_evt; logic power_on;
		logic [3:0] ext_mux; logic ext_connect;
		logic opamp_on; logic ground_on;
		asqc_pins_t pin_analog; asqc_pins_t pullup_off;
	} asqc_top_t;

	// 12-bit value of a byte pair under the chosen alignment
	function automatic asqc_sample_t asqc_align(input logic fmt,
		input asqc_byte_t hi, input asqc_byte_t lo);
		return fmt ? {hi[3:0], lo} : {hi, lo[7:4]};
	endfunction : asqc_align
endpackage : asqc_pkg

// *** asqc_clkdiv.sv ***
// conversion clock divider: one tick every 2**sel system clocks
// assumes: sel from software registers on the same clock
`timescale 1ns/100ps
`include "asqc_cfg.svh"
module asqc_clkdiv #(
	parameter int SEL_W = `ASQC_DIV_SEL_W
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             run,
	input  wire logic [SEL_W-1:0] sel,
	output logic                  tick
);
	import asqc_pkg::*;
	localparam int CW = (1 << SEL_W) - 1;
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tick;
	} asqc_div_t;
	asqc_div_t s_reg, s_next;

	initial begin
		if (SEL_W < 1 || SEL_W > 4) $error("asqc_clkdiv: SEL_W out of range");
	end

	// divide by a power of two, count cleared and held at zero while powered down
	always_comb begin
		logic [CW-1:0] last;
		last = CW'((1 << sel) - 1);
		s_next = s_reg;
		s_next.tick = 1'b0;
		if (!run) begin
			s_next.cnt = '0;
		end else if (s_reg.cnt >= last) begin
			s_next.cnt = '0;
			s_next.tick = 1'b1;
		end else begin
			s_next.cnt = s_reg.cnt + CW'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) s_reg <= '0;
		else s_reg <= s_next;
	end
	assign tick = s_reg.tick;

	a_div_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
		!run |=> !tick) else $error("divider ticks while off");
endmodule : asqc_clkdiv

// *** asqc_delay.sv ***
// start delay: holds a trigger for one clock less than the programmed count
// assumes: arm, enable and count from logic on the same clock
`timescale 1ns/100ps
`include "asqc_cfg.svh"
module asqc_delay #(
	parameter int DW = `ASQC_DLY_W
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          arm,
	input  wire logic          dly_en,
	input  wire logic [DW-1:0] count,
	input  wire logic          cancel,
	output logic               go
);
	import asqc_pkg::*;
	typedef struct packed {
		asqc_dly_state_t st;
		logic [DW-1:0]   cnt;
		logic            go;
	} asqc_dl_t;
	asqc_dl_t s_reg, s_next;

	initial begin
		if (DW < 1 || DW > 16) $error("asqc_delay: DW out of range");
	end

	// count down count-1 clocks from the trigger, then pulse go
	always_comb begin
		s_next = s_reg;
		s_next.go = 1'b0;
		unique case (s_reg.st)
			DLY_IDLE: begin
				if (arm && dly_en && count > DW'(1)) begin
					s_next.st = DLY_COUNT;
					s_next.cnt = count - DW'(1);
				end else if (arm) begin
					s_next.go = 1'b1;
				end
			end
			DLY_COUNT: begin
				if (s_reg.cnt == DW'(1)) begin
					s_next.st = DLY_IDLE;
					s_next.go = 1'b1;
				end else begin
					s_next.cnt = s_reg.cnt - DW'(1);
				end
			end
		endcase
		if (cancel) begin
			s_next.st = DLY_IDLE;
			s_next.go = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) s_reg <= '{st: DLY_IDLE, cnt: '0, go: 1'b0};
		else s_reg <= s_next;
	end
	assign go = s_reg.go;

	a_delay_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		s_reg.st == DLY_COUNT && s_reg.cnt > DW'(1) |=> !go)
		else $error("delayed start fired early");
endmodule : asqc_delay

// *** asqc_core_model.sv ***
// analog core stand-in: answers each conversion start with a sample
// assumes: conv_start is a one-cycle pulse on aclk
`timescale 1ns/100ps
module asqc_core_model (
	input  wire logic        aclk,
	input  wire logic        conv_start,
	input  wire logic        adc_power_on,
	input  wire logic        slow,
	input  wire logic [11:0] sample,
	output logic             adc_done,
	output logic [11:0]      adc_data
);
	// ****************
	// conversion answer
	// ****************
	// data stands from before done rises until done falls
	initial begin
		adc_done = 1'b0;
		adc_data = 12'hFFF;
		forever begin
			@(posedge aclk);
			if (conv_start === 1'b1 && adc_power_on === 1'b1) begin
				repeat (slow ? 20 : 2) @(posedge aclk);
				adc_data <= sample;
				@(posedge aclk);
				adc_done <= 1'b1;
				repeat (5) @(posedge aclk);
				adc_done <= 1'b0;
				adc_data <= ~sample; // released: no stale value
			end
		end
	end
endmodule : asqc_core_model

// *** adc_sequencer_with_limit_compare_tb.sv ***
// self-checking bench of the converter sequencer
// assumes: asqc_pkg compiled first, core model beside the design
`timescale 1ns/100ps
`include "asqc_cfg.svh"
module adc_sequencer_with_limit_compare_tb;
	import asqc_pkg::*;
	// ****************
	// signals
	// ****************
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, adc_done, slow;
	logic pwm_period_flag, adc_power_on, adc_clk_tick, conv_start;
	logic ext_connect, opamp_connect, ground_connect, limit_event;
	logic [1:0] s_axi_bresp, s_axi_rresp, lresp;
	logic [3:0] s_axi_wstrb, ext_mux_sel;
	logic [2:0] pwm_duty_flag;
	asqc_addr_t s_axi_awaddr, s_axi_araddr;
	asqc_word_t s_axi_wdata, s_axi_rdata;
	asqc_sample_t adc_data, smpl;
	asqc_pins_t pin_analog_sel, pullup_disable;
	int fails = 0, tests_run = 0, cyc = 0, cs_cnt = 0, cs_cyc = 0;
	int ev_cnt = 0, tk_cnt = 0;
	typedef struct {logic fmt; logic [1:0] cond; asqc_sample_t smp;
		int ev;} asqc_row_t;
	asqc_row_t rows [8] = '{'{1, 0, 12'h2A5, 1}, '{1, 1, 12'h100, 1},
		'{1, 1, 12'h1C3, 0}, '{1, 2, 12'h300, 1}, '{0, 2, 12'h2FF, 0},
		'{0, 3, 12'h0FF, 1}, '{0, 3, 12'h2B7, 0}, '{0, 0, 12'h3C6, 0}};

	asqc_top asqc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .adc_done, .adc_data,
		.pwm_period_flag, .pwm_duty_flag, .adc_power_on, .adc_clk_tick,
		.conv_start, .ext_mux_sel, .ext_connect, .opamp_connect,
		.ground_connect, .pin_analog_sel, .pullup_disable, .limit_event);
	asqc_core_model asqc_core_model_inst (.aclk, .conv_start,
		.adc_power_on, .slow, .sample(smpl), .adc_done, .adc_data);

	// ****************
	// clock, event counters, watchdog
	// ****************
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	// counts pulses seen on the design's event outputs
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (conv_start === 1'b1) begin
			cs_cnt <= cs_cnt + 1;
			cs_cyc <= cyc;
		end
		if (limit_event === 1'b1) ev_cnt <= ev_cnt + 1;
		if (adc_clk_tick === 1'b1) tk_cnt <= tk_cnt + 1;
	end
	// cuts a hang short
	initial begin
		repeat (20000) @(posedge aclk);
		fails++;
		wrap_up();
	end

	// ****************
	// tasks
	// ****************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask : chk
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	// write: address and data offered together, each dropped when taken
	task automatic wr(input asqc_addr_t a, input asqc_byte_t d);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {24'h0, d};
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		lresp = s_axi_bresp;
	endtask : wr
	task automatic rd(input asqc_addr_t a, output asqc_word_t d);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		lresp = s_axi_rresp;
	endtask : rd
	task automatic rc(input asqc_addr_t a, input asqc_byte_t e);
		asqc_word_t d;
		rd(a, d);
		chk(d, {24'h0, e});
	endtask : rc
	task automatic wait_cs(input int c0);
		for (int n = 0; n < 40 && cs_cnt == c0; n++) @(posedge aclk);
	endtask : wait_cs
	task automatic idle();
		asqc_word_t d;
		d = 32'h40;
		for (int n = 0; n < 40 && d[6] !== 1'b0; n++) rd(`ASQC_OFF_CTRL, d);
	endtask : idle
	task automatic sw_start(input asqc_byte_t c);
		wr(`ASQC_OFF_CTRL, c | 8'h80);
		wr(`ASQC_OFF_CTRL, c);
	endtask : sw_start
	// raises a pwm flag and returns cycles until the conversion start
	task automatic pwm_run(input asqc_byte_t tr, input asqc_byte_t dl,
		input logic [3:0] f, output int t);
		int c0, t0;
		wr(`ASQC_OFF_DLY, dl);
		wr(`ASQC_OFF_TRIG, tr);
		c0 = cs_cnt;
		t0 = cyc;
		{pwm_duty_flag, pwm_period_flag} <= f;
		wait_cs(c0);
		@(posedge aclk);
		t = cs_cyc - t0;
		{pwm_duty_flag, pwm_period_flag} <= 4'h0;
		idle();
	endtask : pwm_run
	function automatic asqc_byte_t hb(input logic f, input asqc_sample_t s);
		return f ? {4'h0, s[11:8]} : s[11:4];
	endfunction : hb
	function automatic asqc_byte_t lb(input logic f, input asqc_sample_t s);
		return f ? s[7:0] : {s[3:0], 4'h0};
	endfunction : lb

	// ****************
	// main sequence
	// ****************
	initial begin
		asqc_word_t d;
		asqc_pins_t ep;
		int c0, e0, t0, t3, t9, td;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
		{s_axi_bready, s_axi_rready, slow, pwm_period_flag} = 4'hC;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_wstrb, pwm_duty_flag, smpl} = {4'hF, 3'h0, 12'h0};
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(`ASQC_OFF_CTRL, 8'h00);
		$display("test reset done");
		// table rows: software start, alignment, limit condition
		for (int i = 0; i < 8; i++) begin
			slow <= i[0];
			smpl <= rows[i].smp;
			wr(`ASQC_OFF_LOL_LO, lb(rows[i].fmt, 12'h100));
			wr(`ASQC_OFF_LOL_HI, hb(rows[i].fmt, 12'h100));
			wr(`ASQC_OFF_UPL_LO, lb(rows[i].fmt, 12'h300));
			wr(`ASQC_OFF_UPL_HI, hb(rows[i].fmt, 12'h300));
			wr(`ASQC_OFF_TRIG, {3'h0, rows[i].cond, 3'h0});
			c0 = cs_cnt;
			e0 = ev_cnt;
			sw_start({3'b001, rows[i].fmt, 4'h2});
			wait_cs(c0);
			chk(cs_cnt - c0, 1);
			rd(`ASQC_OFF_CTRL, d);
			chk(d & 32'h40, 32'h40);
			idle();
			rc(`ASQC_OFF_RES_HI, hb(rows[i].fmt, rows[i].smp));
			rc(`ASQC_OFF_RES_LO, lb(rows[i].fmt, rows[i].smp));
			rc(`ASQC_OFF_UPL_HI, hb(rows[i].fmt, 12'h300));
			chk(ev_cnt - e0, rows[i].ev);
			$display("test row %0d done", i);
		end
		// a start while busy is dropped
		slow <= 1'b1;
		c0 = cs_cnt;
		sw_start(8'h22);
		wait_cs(c0);
		sw_start(8'h22);
		idle();
		chk(cs_cnt - c0, 1);
		$display("test busy start done");
		// channel codes, pin release and internal sources
		for (int c = 0; c < 16; c++) begin
			wr(`ASQC_OFF_CTRL, {4'h2, c[3:0]});
			repeat (2) @(posedge aclk);
			ep = (c == 6 || c > 13) ? 14'h0 : 14'h1 << c;
			chk(pin_analog_sel, ep);
			chk(pullup_disable, ep);
			chk(ext_connect, ep != 0);
			chk(ext_mux_sel, c[3:0]);
		end
		wr(`ASQC_OFF_CTRL, 8'h22);
		wr(`ASQC_OFF_SRCCLK, 8'h23);
		repeat (2) @(posedge aclk);
		t0 = tk_cnt;
		chk({opamp_connect, ext_connect}, 2'b10);
		repeat (64) @(posedge aclk);
		chk(tk_cnt - t0, 8);
		wr(`ASQC_OFF_SRCCLK, 8'h40);
		repeat (2) @(posedge aclk);
		chk({ground_connect, ext_connect}, 2'b10);
		wr(`ASQC_OFF_SRCCLK, 8'h00);
		$display("test channels done");
		// delayed pwm start
		slow <= 1'b0;
		pwm_run(8'h80, 8'h00, 4'h1, t0);
		pwm_run(8'hC0, 8'h03, 4'h1, t3);
		pwm_run(8'hC0, 8'h09, 4'h1, t9);
		pwm_run(8'hA1, 8'h00, 4'h4, td);
		chk(t9 - t3, 6);
		chk(t3 - t0, 2);
		chk(td, t0);
		$display("test pwm start done");
		// disable clears the result, keeps limits, stops the clock
		wr(`ASQC_OFF_CTRL, 8'h02);
		repeat (2) @(posedge aclk);
		t0 = tk_cnt;
		chk(adc_power_on, 1'b0);
		rc(`ASQC_OFF_RES_HI, 8'h00);
		rc(`ASQC_OFF_RES_LO, 8'h00);
		rc(`ASQC_OFF_LOL_HI, 8'h10);
		rc(`ASQC_OFF_UPL_HI, 8'h30);
		chk(tk_cnt - t0, 0);
		$display("test disable done");
		// unmapped address is refused on both paths
		rd(8'h30, d);
		chk(lresp, 2'h2);
		chk(d, 32'h0);
		wr(8'h30, 8'h55);
		chk(lresp, 2'h2);
		$display("test unmapped done");
		// second reset in mid-run
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(`ASQC_OFF_LOL_HI, 8'h00);
		$display("test second reset done");
		wrap_up();
	end
endmodule : adc_sequencer_with_limit_compare_tb
